// ==== bench/sapc_chk.sv ====
`timescale 1ns/100ps
// checks host port and completion flag behaviour at the top ports
module sapc_chk (
   input wire clk_i,
   input wire rstn_i,
   input wire cs_n_i,
   input wire wr_n_i,
   input wire rd_n_i,
   input wire upper_byte_sel_i,
   input wire conv_clk_i,
   input wire [7:0] data_i,
   input wire cmp_hi_i,
   input wire [7:0] data_o,
   input wire data_oe_o,
   input wire done_n_o,
   input wire track_o,
   input wire [2:0] chan_sel_o,
   input wire single_vs_pair_sel_o,
   input wire powered_o
);
   reg wr_q;
   reg cs_q;
   reg [7:0] word;
   wire take = wr_n_i && !wr_q && !cs_q;
   // remembers the strobes and the last setup word taken
   always @(posedge clk_i) begin
      wr_q <= wr_n_i;
      cs_q <= cs_n_i;
      if (take) begin
         word <= data_i;
      end
   end
   default clocking @(posedge clk_i); endclocking
   default disable iff (!rstn_i);
   a_oe_tracks_read: assert property (data_oe_o == (!$past(cs_n_i) && !$past(rd_n_i)))
      else $error("output enable not tied to select and read");
   a_read_clears_flag: assert property ($fell(rd_n_i) && !cs_n_i && !done_n_o |-> ##[1:2] done_n_o)
      else $error("flag not released by read");
   a_write_clears_flag: assert property (take && !done_n_o |-> ##[1:2] done_n_o)
      else $error("flag not released by setup write");
   a_select_blocks_setup: assert property (cs_n_i [*3] |=> $stable(chan_sel_o))
      else $error("setup changed while deselected");
   a_done_when_powered: assert property ($fell(done_n_o) |-> powered_o)
      else $error("conversion finished while powered down");
   a_track_no_flag: assert property (track_o && $past(track_o) |-> done_n_o)
      else $error("flag low during acquisition");
   a_upper_byte_fill: assert property (data_oe_o && $past(upper_byte_sel_i) &&
      $past(upper_byte_sel_i, 2) |-> data_o[7:2] == 6'h00 || data_o[7:2] == 6'h3F)
      else $error("upper byte fill bits not uniform");
   a_quiet_after_write: assert property (take |-> ##2 done_n_o [*8])
      else $error("flag low too soon after write");
   a_chan_from_bus: assert property (take |-> ##2 chan_sel_o == word[2:0] &&
      single_vs_pair_sel_o == word[4])
      else $error("setup fields not taken from data lines");
endmodule
bind sapc_top sapc_chk sapc_chk_i (.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n_i),
   .wr_n_i(wr_n_i), .rd_n_i(rd_n_i), .upper_byte_sel_i(upper_byte_sel_i),
   .conv_clk_i(conv_clk_i), .data_i(data_i), .cmp_hi_i(cmp_hi_i), .data_o(data_o),
   .data_oe_o(data_oe_o), .done_n_o(done_n_o), .track_o(track_o), .chan_sel_o(chan_sel_o),
   .single_vs_pair_sel_o(single_vs_pair_sel_o), .powered_o(powered_o));

// ==== bench/sapc_host.sv ====
`timescale 1ns/100ps
// host side: setup writes, result reads and the conversion clock
module sapc_host (
   input wire clk_i,
   input wire [7:0] rdata_i,
   output reg cs_n_o,
   output reg wr_n_o,
   output reg rd_n_o,
   output reg hsel_o,
   output reg cclk_o,
   output reg [7:0] wdata_o
);
   // idle levels, then a free running clock near 4.76 MHz
   initial begin
      cs_n_o = 1'b1;
      wr_n_o = 1'b1;
      rd_n_o = 1'b1;
      hsel_o = 1'b0;
      wdata_o = 8'h00;
      cclk_o = 1'b0;
      forever #105 cclk_o = ~cclk_o;
   end
   // one setup write; cs_n high gives a write the device must ignore;
   // select stays at cs_n afterwards so the conversion clock keeps counting
   task wr(input [7:0] w, input cs_n);
      begin
         @(posedge clk_i) #1;
         cs_n_o = cs_n;
         wr_n_o = 1'b0;
         wdata_o = w;
         @(posedge clk_i) #1;
         wr_n_o = 1'b1;
         @(posedge clk_i) #1;
         wdata_o = ~w; // released lines carry no stale word
      end
   endtask
   // one read with select and read held low throughout
   task rd(input hs, output [7:0] q);
      begin
         @(posedge clk_i) #1;
         cs_n_o = 1'b0;
         rd_n_o = 1'b0;
         hsel_o = hs;
         repeat (3) @(posedge clk_i);
         #1;
         q = rdata_i;
         rd_n_o = 1'b1;
      end
   endtask
endmodule

// ==== bench/tb.sv ====
`timescale 1ns/100ps
module tb;
   reg clk_i;
   reg rstn_i;
   reg cmp_hi;
   reg [7:0] b;
   wire cs_n, wr_n, rd_n, hsel, cclk, oe, done_n, track, single, powered;
   wire [7:0] wd, q;
   wire [2:0] chan;
   integer miscompares, total_checks, n;
   // 200 MHz system clock
   initial begin
      clk_i = 1'b0;
      forever #2.5 clk_i = ~clk_i;
   end
   sapc_host sapc_host_i (.clk_i(clk_i), .rdata_i(q), .cs_n_o(cs_n), .wr_n_o(wr_n),
      .rd_n_o(rd_n), .hsel_o(hsel), .cclk_o(cclk), .wdata_o(wd));
   sapc_top sapc_top_i (.clk_i(clk_i), .rstn_i(rstn_i), .cs_n_i(cs_n), .wr_n_i(wr_n),
      .rd_n_i(rd_n), .upper_byte_sel_i(hsel), .conv_clk_i(cclk), .data_i(wd),
      .cmp_hi_i(cmp_hi), .data_o(q), .data_oe_o(oe), .done_n_o(done_n), .track_o(track),
      .chan_sel_o(chan), .single_vs_pair_sel_o(single), .powered_o(powered));
   task check(input [7:0] seen, input [7:0] exp);
      begin
         total_checks = total_checks + 1;
         if (seen !== exp) begin
            miscompares = miscompares + 1;
            $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
         end
      end
   endtask
   task test_done;
      begin
         $display("checks %0d miscompares %0d", total_checks, miscompares);
         if (miscompares == 0 && total_checks > 0) $display("Test passed");
         else $display("Test failed");
         $finish;
      end
   endtask
   // waits for the flag, at most lim cycles, counting them in n
   task wait_done(input integer lim);
      begin
         n = 0;
         while (done_n !== 1'b0 && n < lim) begin
            @(posedge clk_i);
            n = n + 1;
         end
         #1;
      end
   endtask
   // watchdog
   initial begin
      #200000;
      miscompares = miscompares + 1;
      test_done;
   end
   // main sequence
   initial begin
      miscompares = 0;
      total_checks = 0;
      rstn_i = 1'b0;
      cmp_hi = 1'b1;
      repeat (8) @(posedge clk_i);
      #1 rstn_i = 1'b1;
      check({powered, done_n, oe, single, 1'b0, chan}, 8'hC0);
      sapc_host_i.wr(8'hDD, 1'b0);
      wait_done(2000);
      check({done_n, 6'h00, n >= 620 && n <= 680}, 8'h01);
      check({3'h0, single, 1'b0, chan}, 8'h15);
      sapc_host_i.rd(1'b0, b);
      check(b, 8'hFF);
      check({7'h00, done_n}, 8'h01);
      sapc_host_i.rd(1'b1, b);
      check(b, 8'h03);
      sapc_host_i.rd(1'b0, b);
      check(b, 8'hFF);
      cmp_hi = 1'b0;
      sapc_host_i.wr(8'h82, 1'b0);
      wait_done(2000);
      check({done_n, 6'h00, n >= 860 && n <= 920}, 8'h01);
      check({3'h0, single, 1'b0, chan}, 8'h02);
      sapc_host_i.rd(1'b0, b);
      check(b, 8'h00);
      sapc_host_i.rd(1'b1, b);
      check(b, 8'hFE);
      cmp_hi = 1'b1;
      sapc_host_i.wr(8'hFB, 1'b0);
      repeat (2000) @(posedge clk_i);
      #1;
      check({6'h00, track, done_n}, 8'h03);
      sapc_host_i.wr(8'h9B, 1'b0);
      wait_done(2000);
      check({done_n, 6'h00, n >= 660 && n <= 720}, 8'h01);
      sapc_host_i.wr(8'hDD, 1'b0);
      repeat (300) @(posedge clk_i);
      sapc_host_i.wr(8'hDD, 1'b0);
      wait_done(2000);
      check({done_n, 6'h00, n >= 620 && n <= 680}, 8'h01);
      sapc_host_i.wr(8'h1D, 1'b0);
      repeat (2000) @(posedge clk_i);
      #1;
      check({6'h00, powered, done_n}, 8'h01);
      sapc_host_i.wr(8'h5D, 1'b0);
      sapc_host_i.wr(8'hC2, 1'b1);
      repeat (2000) @(posedge clk_i);
      #1;
      check({powered, done_n, 3'h0, chan}, 8'h45);
      test_done;
   end
endmodule

// ==== hw/sapc_map.vh ====
`ifndef SAPC_MAP_VH
`define SAPC_MAP_VH
// setup word field positions
`define SAPC_PWR_HI_BIT 7
`define SAPC_PWR_LO_BIT 6
`define SAPC_ACQ_BIT 5
`define SAPC_SGL_BIT 4
`define SAPC_POL_BIT 3
`define SAPC_CHAN_MSB 2
`define SAPC_CHAN_LSB 0
// power and clock mode codes
`define SAPC_PWR_FULL_DOWN 2'h0
`define SAPC_PWR_STANDBY 2'h1
`define SAPC_PWR_NORM_INT 2'h2
`define SAPC_PWR_NORM_EXT 2'h3
// reset value of the setup word: normal operation, external clock
`define SAPC_SETUP_RESET 8'hC0
// timing
`define SAPC_ACQ_EXT_CYCLES 3
`define SAPC_CONV_CYCLES 13
`define SAPC_ACQ_INT_NS 1000
`define SAPC_CONV_INT_NS 3600
`define SAPC_CLK_NS 5
`endif

// ==== hw/sapc_sar_engine.v ====
`timescale 1ns/100ps
`include "sapc_map.vh"
// successive-approximation core: one decision per conversion tick on ticks 3 to 12 of 13,
// compares the trial code against the analog comparator input
module sapc_sar_engine #(
   parameter WIDTH = 10
) (
   input wire clk_i,
   input wire rstn_i,
   input wire start_i,
   input wire abort_i,
   input wire tick_i,
   input wire cmp_hi_i,
   output reg busy_o,
   output reg done_o,
   output reg [WIDTH-1:0] trial_o
);
   reg [WIDTH-1:0] bit_mask;
   reg [3:0] step;

   // thirteen ticks: first ticks settle, then one bit per tick, MSB first
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         busy_o <= 1'b0;
         done_o <= 1'b0;
         trial_o <= {WIDTH{1'b0}};
         bit_mask <= {WIDTH{1'b0}};
         step <= 4'h0;
      end else begin
         done_o <= 1'b0;
         if (abort_i) begin
            busy_o <= 1'b0;
         end else if (start_i) begin
            busy_o <= 1'b1;
            step <= 4'h0;
            trial_o <= {1'b1, {(WIDTH-1){1'b0}}};
            bit_mask <= {1'b1, {(WIDTH-1){1'b0}}};
         end else if (busy_o && tick_i) begin
            step <= step + 4'h1;
            if (step >= 4'h2 && bit_mask != {WIDTH{1'b0}}) begin
               // keep the trial bit if input is at or above trial level
               trial_o <= (cmp_hi_i ? trial_o : (trial_o & ~bit_mask))
                          | (bit_mask >> 1);
               bit_mask <= bit_mask >> 1;
            end
            if (step == 4'd12) begin
               busy_o <= 1'b0;
               done_o <= 1'b1;
            end
         end
      end
   end
endmodule

// ==== hw/sapc_top.v ====
`timescale 1ns/100ps
`include "sapc_map.vh"
module sapc_top #(
   parameter WIDTH = 10
) (
   input wire clk_i,
   input wire rstn_i,
   input wire cs_n_i,
   input wire wr_n_i,
   input wire rd_n_i,
   input wire upper_byte_sel_i,
   input wire conv_clk_i,
   input wire [7:0] data_i,
   input wire cmp_hi_i,
   output reg [7:0] data_o,
   output reg data_oe_o,
   output reg done_n_o,
   output reg track_o,
   output reg [2:0] chan_sel_o,
   output reg single_vs_pair_sel_o,
   output reg powered_o
);
   // internal conversion tick period: 3.6us over 13 ticks, rounded down
   localparam INT_TICK = (`SAPC_CONV_INT_NS / `SAPC_CLK_NS) / `SAPC_CONV_CYCLES;
   // internal acquisition: about 1us, rounded up
   localparam INT_ACQ = (`SAPC_ACQ_INT_NS + `SAPC_CLK_NS - 1) / `SAPC_CLK_NS;
   localparam ST_IDLE = 2'h0;
   localparam ST_ACQ_INT = 2'h1;
   localparam ST_ACQ_EXT = 2'h2;
   localparam ST_CONV = 2'h3;

   reg [7:0] setup;
   reg ext_clk_mode;
   reg [1:0] state;
   reg wr_q;
   reg rd_q;
   reg cclk_q;
   reg [9:0] div_cnt;
   reg [9:0] acq_cnt;
   reg [WIDTH-1:0] result;
   wire wr_rise;
   wire rd_fall;
   wire cclk_fall;
   wire int_tick;
   wire tick;
   wire start;
   wire abort;
   wire busy;
   wire done;
   wire [WIDTH-1:0] trial;
   wire [1:0] pwr;
   wire pwr_normal;

   // strobes only count while chip-select is low
   wire wr_act = !cs_n_i && !wr_n_i;
   wire rd_act = !cs_n_i && !rd_n_i;
   wire cclk_act = !cs_n_i && conv_clk_i;
   assign wr_rise = wr_q && !wr_act;
   assign rd_fall = rd_act && !rd_q;
   assign cclk_fall = cclk_q && !cclk_act;
   assign int_tick = (div_cnt == (INT_TICK[9:0] - 10'h1));
   // active conversion clock
   assign tick = ext_clk_mode ? cclk_fall : int_tick;
   assign pwr = data_i[`SAPC_PWR_HI_BIT:`SAPC_PWR_LO_BIT];
   assign pwr_normal = setup[`SAPC_PWR_HI_BIT];

   // strobe history
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         wr_q <= 1'b0;
         rd_q <= 1'b0;
         cclk_q <= 1'b0;
      end else begin
         wr_q <= wr_act;
         rd_q <= rd_act;
         cclk_q <= cclk_act;
      end
   end

   // setup word capture and clock-mode memory
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         setup <= `SAPC_SETUP_RESET;
         ext_clk_mode <= 1'b1;
      end else if (wr_rise) begin
         setup <= data_i;
         if (pwr == `SAPC_PWR_NORM_INT)
            ext_clk_mode <= 1'b0;
         else if (pwr == `SAPC_PWR_NORM_EXT)
            ext_clk_mode <= 1'b1;
         // power-down codes leave the clock mode alone
      end
   end

   // internal clock divider, free running
   always @(posedge clk_i) begin
      if (!rstn_i)
         div_cnt <= 10'h0;
      else if (int_tick)
         div_cnt <= 10'h0;
      else
         div_cnt <= div_cnt + 10'h1;
   end

   // a conversion starts when the acquisition count runs out, or when a write with ACQ clear ends ST_ACQ_EXT
   assign start = (state == ST_ACQ_INT && ((ext_clk_mode && cclk_fall
                   && acq_cnt == `SAPC_ACQ_EXT_CYCLES - 1)
                  || (!ext_clk_mode && acq_cnt == INT_ACQ[9:0] - 10'h1)))
                  || (state == ST_ACQ_EXT && wr_rise && !data_i[`SAPC_ACQ_BIT]);
   assign abort = wr_rise && state == ST_CONV;

   // acquisition and conversion sequencing
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         state <= ST_IDLE;
         acq_cnt <= 10'h0;
      end else begin
         case (state)
            ST_ACQ_INT: begin
               if (wr_rise) begin
                  // any new setup restarts; power-down codes stop here
                  acq_cnt <= 10'h0;
                  if (!data_i[`SAPC_PWR_HI_BIT])
                     state <= ST_IDLE;
                  else if (data_i[`SAPC_ACQ_BIT])
                     state <= ST_ACQ_EXT;
                  else
                     state <= ST_ACQ_INT;
               end else if (start) begin
                  state <= ST_CONV;
               end else if (!ext_clk_mode || cclk_fall) begin
                  acq_cnt <= acq_cnt + 10'h1;
               end
            end
            ST_ACQ_EXT: begin
               if (start) begin
                  // power bits of this write may differ
                  state <= ST_CONV;
               end else if (wr_rise) begin
                  acq_cnt <= 10'h0; // another open acquisition
               end
            end
            default: begin
               if (wr_rise) begin
                  acq_cnt <= 10'h0;
                  // power-down codes start nothing, standby included; only normal codes start an acquisition
                  if (!data_i[`SAPC_PWR_HI_BIT])
                     state <= ST_IDLE;
                  else if (data_i[`SAPC_ACQ_BIT])
                     state <= ST_ACQ_EXT;
                  else
                     state <= ST_ACQ_INT;
               end else if (state == ST_CONV && done) begin
                  state <= ST_IDLE;
               end
            end
         endcase
      end
   end

   sapc_sar_engine #(
      .WIDTH(WIDTH)
   ) u_sar (
      .clk_i(clk_i),
      .rstn_i(rstn_i),
      .start_i(start),
      .abort_i(abort),
      .tick_i(tick),
      .cmp_hi_i(cmp_hi_i),
      .busy_o(busy),
      .done_o(done),
      .trial_o(trial)
   );

   // result register, completion flag and analog controls
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         result <= {WIDTH{1'b0}};
         done_n_o <= 1'b1;
         track_o <= 1'b0;
         chan_sel_o <= 3'h0;
         single_vs_pair_sel_o <= 1'b0;
         powered_o <= 1'b1;
      end else begin
         if (done && state == ST_CONV) begin
            // bipolar flips the MSB to give two's complement
            result <= setup[`SAPC_POL_BIT] ? trial
                      : {~trial[WIDTH-1], trial[WIDTH-2:0]};
            done_n_o <= 1'b0;
         end else if (rd_fall || wr_rise) begin
            done_n_o <= 1'b1;
         end
         track_o <= (state == ST_ACQ_INT) || (state == ST_ACQ_EXT);
         chan_sel_o <= setup[`SAPC_CHAN_MSB:`SAPC_CHAN_LSB];
         single_vs_pair_sel_o <= setup[`SAPC_SGL_BIT];
         powered_o <= pwr_normal || busy;
      end
   end

   // read port: byte select picks the driven half
   always @(posedge clk_i) begin
      if (!rstn_i) begin
         data_o <= 8'h00;
         data_oe_o <= 1'b0;
      end else begin
         data_oe_o <= rd_act;
         if (!upper_byte_sel_i)
            data_o <= result[7:0];
         else if (setup[`SAPC_POL_BIT])
            data_o <= {6'h00, result[9:8]};
         else
            data_o <= {{6{result[9]}}, result[9:8]};
      end
   end
endmodule
